// >>> hw/burst_sram_port.sv
// Four-word burst SRAM core with separate read and write data ports.
// Assumes all pins are synchronous to clk (one clk edge is one positive input
// clock rise) and that k_running reports whether the input clock pair runs.
`timescale 1ns/1ps
module burst_sram_port
    import burst_port_pkg::*;
#(
    parameter int DATA_W      = burst_port_pkg::DATA_W_DEF,
    parameter int ADDR_W      = burst_port_pkg::ADDR_W_DEF,
    parameter int LOCK_CYCLES_P = burst_port_pkg::LOCK_CYCLES
) (
    input  wire logic              clk,                      // Positive input clock rise.
    input  wire logic              rst,                      // Async reset, active high.
    input  wire logic              k_running,                // Input clock pair is running.
    input  wire logic              delay_loop_disable_n,     // Low selects legacy latency.
    input  wire logic              output_clocks_high,       // Strap: single clock mode.
    input  wire logic              read_port_select_n,       // Read start, active low.
    input  wire logic              write_port_select_n,      // Write start, active low.
    input  wire logic [ADDR_W-1:0] addr,                     // Shared burst address.
    input  wire logic [DATA_W-1:0] wdata_rise,               // Beat on positive phase.
    input  wire logic [DATA_W-1:0] wdata_fall,               // Beat on negative phase.
    input  wire logic [1:0]        lane_write_select_n_rise, // Lanes, positive beat.
    input  wire logic [1:0]        lane_write_select_n_fall, // Lanes, negative beat.
    output logic [DATA_W-1:0]      rdata_rise,               // Word on positive phase.
    output logic [DATA_W-1:0]      rdata_fall,               // Word on negative phase.
    output logic                   rdata_oe_rise,            // Positive-phase word driven.
    output logic                   rdata_oe_fall,            // Negative-phase word driven.
    output logic                   dll_locked,               // Delay loop locked.
    output logic                   single_clock_mode         // Strap captured after reset release.
);
    import burst_port_pkg::*;

    localparam int LO_W = DATA_W / LANES;

    // Elaboration checks: the lane split needs an even width, and the lock
    // counter must be able to reach the lock count.
    if (DATA_W < 2 || (DATA_W % LANES) != 0) begin : g_bad_width
        $error("DATA_W must be even and at least 2");
    end
    if (LOCK_CYCLES_P < 1 || LOCK_CYCLES_P >= (1 << LOCK_CNT_W)) begin : g_bad_lock
        $error("LOCK_CYCLES_P out of counter range");
    end

    // ==========================================================
    // Helpers
    // ==========================================================
    // Merge one beat into the stored word; a deselected lane keeps its value.
    function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_w,
                                                      input logic [DATA_W-1:0] new_w,
                                                      input logic [1:0]        sel_n);
        logic [DATA_W-1:0] res;
        res = old_w;
        if ((sel_n & LANE_LO_N) == 2'h0)
            res[LO_W-1:0] = new_w[LO_W-1:0];
        if ((sel_n & LANE_HI_N) == 2'h0)
            res[DATA_W-1:LO_W] = new_w[DATA_W-1:LO_W];
        return res;
    endfunction

    // Address of a burst position; wraps at the top of the array.
    function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] base,
                                                    input logic [1:0]        ofs);
        return base + ADDR_W'(ofs);
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    logic [DATA_W-1:0]     mem [0:(1 << ADDR_W)-1];
    logic [LOCK_CNT_W-1:0] lock_cnt;
    logic [STOP_CNT_W-1:0] stop_cnt;
    last_op_e              last_op;
    logic                  wr1, wr2;
    logic [ADDR_W-1:0]     wa1, wa2;
    logic                  rd1, rd2, rd3;
    logic [ADDR_W-1:0]     ra1, ra2, ra3;
    logic                  strap_taken;

    // ==========================================================
    // Arbitration and request decode
    // ==========================================================
    // A select used on the previous rise is a don't-care now, so a repeated
    // request of one kind simply never starts.
    wire logic last_rd   = (last_op == OP_READ);
    wire logic last_wr   = (last_op == OP_WRITE);
    wire logic start_rd  = k_running && !read_port_select_n && !last_rd;
    wire logic start_wr  = k_running && !write_port_select_n && !last_wr && !start_rd;
    wire logic legacy    = !delay_loop_disable_n;
    // The current stopped edge counts too, so the clear lands on the last edge
    // of the minimum stop rather than one edge late.
    wire logic stop_long = (stop_cnt >= STOP_CNT_W'(STOP_CYCLES - 1));
    wire logic lock_done = (lock_cnt == LOCK_CNT_W'(LOCK_CYCLES_P));
    wire last_op_e next_last_op = last_op_e'(start_rd ? OP_READ
                                                      : (start_wr ? OP_WRITE : OP_IDLE));

    // Read word selection per phase for both latency modes.
    wire logic next_oe_rise = legacy ? (rd1 || rd2) : (rd2 || rd3);
    wire logic next_oe_fall = rd1 || rd2;
    wire logic [ADDR_W-1:0] rise_a = legacy ? (rd1 ? ra1 : beat_addr(ra2, BEAT_2))
                                            : (rd2 ? beat_addr(ra2, BEAT_1)
                                                   : beat_addr(ra3, BEAT_3));
    wire logic [ADDR_W-1:0] fall_a = legacy ? (rd1 ? beat_addr(ra1, BEAT_1)
                                                   : beat_addr(ra2, BEAT_3))
                                            : (rd1 ? ra1 : beat_addr(ra2, BEAT_2));

    // ==========================================================
    // Delay loop lock tracking
    // ==========================================================
    // The loop relocks on its own once the clock runs steadily again.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_cnt <= '0;
            stop_cnt <= '0;
        end else if (!k_running) begin
            stop_cnt <= stop_long ? stop_cnt : stop_cnt + 1'b1;
            lock_cnt <= stop_long ? '0 : lock_cnt;
        end else begin
            stop_cnt <= '0;
            lock_cnt <= lock_done ? lock_cnt : lock_cnt + 1'b1;
        end
    end
    assign dll_locked = lock_done && delay_loop_disable_n;

    // Single clock strap is caught on the first edge after reset release, since
    // the mode cannot change while the device runs.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_taken       <= 1'b0;
            single_clock_mode <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken       <= 1'b1;
            single_clock_mode <= output_clocks_high;
        end
    end

    // ==========================================================
    // Request pipelines
    // ==========================================================
    // Everything freezes while the clock is stopped.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_op <= OP_IDLE;
            wr1     <= 1'b0;
            wr2     <= 1'b0;
            rd1     <= 1'b0;
            rd2     <= 1'b0;
            rd3     <= 1'b0;
            wa1     <= '0;
            wa2     <= '0;
            ra1     <= '0;
            ra2     <= '0;
            ra3     <= '0;
        end else if (k_running) begin
            last_op <= next_last_op;
            wr1 <= start_wr;
            wa1 <= addr;
            wr2 <= wr1;
            wa2 <= beat_addr(wa1, BEAT_2);
            rd1 <= start_rd;
            ra1 <= addr;
            rd2 <= rd1;
            ra2 <= ra1;
            rd3 <= rd2;
            ra3 <= ra2;
        end
    end

    // ==========================================================
    // Array write, two beats per cycle
    // ==========================================================
    // Outside a write burst the data pins are ignored.
    always_ff @(posedge clk) begin
        if (k_running && wr1) begin
            mem[wa1] <= merge_lanes(mem[wa1], wdata_rise, lane_write_select_n_rise);
            mem[beat_addr(wa1, BEAT_1)] <= merge_lanes(mem[beat_addr(wa1, BEAT_1)],
                                                       wdata_fall, lane_write_select_n_fall);
        end else if (k_running && wr2) begin
            mem[wa2] <= merge_lanes(mem[wa2], wdata_rise, lane_write_select_n_rise);
            mem[beat_addr(wa2, BEAT_1)] <= merge_lanes(mem[beat_addr(wa2, BEAT_1)],
                                                       wdata_fall, lane_write_select_n_fall);
        end
    end

    // ==========================================================
    // Read output registers
    // ==========================================================
    // Enables drop once the pending burst has gone out, letting another
    // device share the bus without a wait state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_oe_rise <= 1'b0;
            rdata_oe_fall <= 1'b0;
            rdata_rise    <= '0;
            rdata_fall    <= '0;
        end else if (k_running) begin
            rdata_oe_rise <= next_oe_rise;
            rdata_oe_fall <= next_oe_fall;
            if (next_oe_rise)
                rdata_rise <= mem[rise_a];
            if (next_oe_fall)
                rdata_fall <= mem[fall_a];
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_lock_wait;
        @(posedge clk) disable iff (rst)
            $rose(lock_done) |-> $past(k_running)
                && ($past(lock_cnt) == LOCK_CNT_W'(LOCK_CYCLES_P - 1));
    endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("locked before count");

    property p_stop_unlock;
        @(posedge clk) disable iff (rst) (!k_running)[*4] |=> !dll_locked;
    endproperty
    a_stop_unlock: assert property (p_stop_unlock) else $error("lock kept after stop");

    property p_legacy_read;
        @(posedge clk) disable iff (rst)
            (start_rd && legacy) ##1 (k_running && legacy) |=> rdata_oe_rise && rdata_oe_fall;
    endproperty
    a_legacy_read: assert property (p_legacy_read) else $error("legacy word0 late");

    property p_dll_read;
        @(posedge clk) disable iff (rst)
            (start_rd && !legacy) ##1 (k_running && !legacy)[*2]
                |-> rdata_oe_fall ##1 (rdata_oe_rise && rdata_oe_fall);
    endproperty
    a_dll_read: assert property (p_dll_read) else $error("read phase order wrong");

    property p_no_back_read;
        @(posedge clk) disable iff (rst) start_rd |=> !start_rd;
    endproperty
    a_no_back_read: assert property (p_no_back_read) else $error("read back to back");

    property p_no_back_write;
        @(posedge clk) disable iff (rst) start_wr |=> !start_wr;
    endproperty
    a_no_back_write: assert property (p_no_back_write) else $error("write back to back");

    property p_arbiter;
        @(posedge clk) disable iff (rst)
            (k_running && !read_port_select_n && !write_port_select_n)
                |-> (last_rd ? start_wr : start_rd);
    endproperty
    a_arbiter: assert property (p_arbiter) else $error("arbiter order wrong");

    property p_release;
        @(posedge clk) disable iff (rst)
            (k_running && !rd1 && !rd2 && !rd3) |=> !rdata_oe_rise && !rdata_oe_fall;
    endproperty
    a_release: assert property (p_release) else $error("outputs not released");

    property p_stop_hold;
        @(posedge clk) disable iff (rst)
            !k_running |=> $stable(rdata_rise) && $stable(rdata_oe_fall) && $stable(last_op);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("state moved when stopped");

    c_legacy_read: cover property (@(posedge clk) disable iff (rst) start_rd && legacy);
    c_dll_read:    cover property (@(posedge clk) disable iff (rst) start_rd && !legacy);
    c_write:       cover property (@(posedge clk) disable iff (rst) start_wr ##2 start_wr);
    c_both_sel:    cover property (@(posedge clk) disable iff (rst)
                                   start_rd ##1 start_wr ##1 start_rd);
endmodule // burst_sram_port

// >>> shared/burst_port_pkg.sv
// Shared constants for the four-word burst SRAM port model.
// Assumes one clock that stands for the positive input clock rise; the
// negative-phase beats travel on separate ports in the same cycle.
package burst_port_pkg;
    // ==========================================================
    // Clock and delay-loop timing
    // ==========================================================
    localparam int CLK_PERIOD_PS  = 8000;    // 125 MHz clock period.
    localparam int STOP_TIME_PS   = 30000;   // Least clock stop that resets the loop.
    // Least time rounds up to whole cycles.
    localparam int STOP_CYCLES    = (STOP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOCK_CYCLES    = 1024;    // Stable cycles before lock.
    localparam int LOCK_CNT_W     = 11;      // Holds 0 to LOCK_CYCLES.
    localparam int STOP_CNT_W     = 4;       // Holds 0 to STOP_CYCLES.

    // ==========================================================
    // Data and burst layout
    // ==========================================================
    localparam int DATA_W_DEF     = 18;      // Word width (x18 part).
    localparam int ADDR_W_DEF     = 20;      // Word address width.
    localparam int LANES          = 2;       // Write-select lanes per word.
    localparam int BURST_LEN      = 4;       // Words per burst.
    localparam int BEAT_OFS_W     = 2;       // Width of a beat offset.
    localparam logic [1:0] SEL_NONE_N = 2'h3; // All lanes deselected.
    localparam logic [1:0] LANE_LO_N  = 2'h1; // Lane 0 select bit position mask.
    localparam logic [1:0] LANE_HI_N  = 2'h2; // Lane 1 select bit position mask.
    localparam logic [1:0] BEAT_0 = 2'h0;
    localparam logic [1:0] BEAT_1 = 2'h1;
    localparam logic [1:0] BEAT_2 = 2'h2;
    localparam logic [1:0] BEAT_3 = 2'h3;

    // Last operation started, used by the port arbiter.
    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } last_op_e;
endpackage

// >>> verif/sram_ctrl_model.sv
// Memory controller model: drives selects, shared address and write beats.
// Assumes the bench calls one task per clock edge, in the order it wants.
`timescale 1ns/1ps
module sram_ctrl_model #(
    parameter int AW = 8,
    parameter int DW = 18
) (
    input  wire logic          clk,                      // Input clock rise.
    output logic               read_port_select_n,       // Read start, active low.
    output logic               write_port_select_n,      // Write start, active low.
    output logic [AW-1:0]      addr,                     // Shared burst address.
    output logic [DW-1:0]      wdata_rise,               // Beat on positive phase.
    output logic [DW-1:0]      wdata_fall,               // Beat on negative phase.
    output logic [1:0]         lane_write_select_n_rise, // Lanes, positive beat.
    output logic [1:0]         lane_write_select_n_fall  // Lanes, negative beat.
);
    // ==========================================================
    // Drive tasks
    // ==========================================================
    // Power-up leaves both ports deselected and every lane off.
    initial begin
        read_port_select_n = 1'b1;
        write_port_select_n = 1'b1;
        addr = '0;
        wdata_rise = '0;
        wdata_fall = '0;
        lane_write_select_n_rise = 2'h3;
        lane_write_select_n_fall = 2'h3;
    end

    // One edge of drive; what is set here is sampled at the following edge.
    task automatic step(input logic r_n, input logic w_n, input logic [AW-1:0] a,
                        input logic [DW-1:0] dr, input logic [DW-1:0] df,
                        input logic [1:0] lr, input logic [1:0] lf);
        @(posedge clk);
        read_port_select_n <= r_n;
        write_port_select_n <= w_n;
        addr <= a;
        wdata_rise <= dr;
        wdata_fall <= df;
        lane_write_select_n_rise <= lr;
        lane_write_select_n_fall <= lf;
    endtask

    // Released lines flip so a stale value can never pass for a fresh one, and
    // the lanes stay selected so a stray write while idle would show.
    task automatic idle();
        @(posedge clk);
        read_port_select_n <= 1'b1;
        write_port_select_n <= 1'b1;
        addr <= ~addr;
        wdata_rise <= ~wdata_rise;
        wdata_fall <= ~wdata_fall;
        lane_write_select_n_rise <= 2'h0;
        lane_write_select_n_fall <= 2'h0;
    endtask
endmodule // sram_ctrl_model

// >>> verif/tb.sv
// Self-checking bench for the burst SRAM port, with a controller model.
// Assumes the design's hand-over timing: one clk edge per input clock rise.
`timescale 1ns/1ps
module tb;
    logic              clk;
    logic              rst;
    logic              k_running;
    logic              delay_loop_disable_n;
    logic              output_clocks_high;
    wire logic         rps_n;
    wire logic         wps_n;
    wire logic [7:0]   addr;
    wire logic [17:0]  wd_r;
    wire logic [17:0]  wd_f;
    wire logic [1:0]   ls_r;
    wire logic [1:0]   ls_f;
    logic [17:0]       rdata_rise;
    logic [17:0]       rdata_fall;
    logic              rdata_oe_rise;
    logic              rdata_oe_fall;
    logic              dll_locked;
    logic              single_clock_mode;
    logic [17:0]       model [0:255];
    int                error_cnt = 0;
    int                n_tests = 0;

    // ==========================================================
    // Clock, design and controller
    // ==========================================================
    initial clk = 1'b0;
    always #4 clk = ~clk;

    burst_sram_port #(.DATA_W(18), .ADDR_W(8), .LOCK_CYCLES_P(16)) dut_u (
        .clk(clk), .rst(rst), .k_running(k_running),
        .delay_loop_disable_n(delay_loop_disable_n), .output_clocks_high(output_clocks_high),
        .read_port_select_n(rps_n), .write_port_select_n(wps_n), .addr(addr),
        .wdata_rise(wd_r), .wdata_fall(wd_f),
        .lane_write_select_n_rise(ls_r), .lane_write_select_n_fall(ls_f),
        .rdata_rise(rdata_rise), .rdata_fall(rdata_fall), .rdata_oe_rise(rdata_oe_rise),
        .rdata_oe_fall(rdata_oe_fall), .dll_locked(dll_locked),
        .single_clock_mode(single_clock_mode));

    sram_ctrl_model #(.AW(8), .DW(18)) ctrl_u (
        .clk(clk), .read_port_select_n(rps_n), .write_port_select_n(wps_n), .addr(addr),
        .wdata_rise(wd_r), .wdata_fall(wd_f),
        .lane_write_select_n_rise(ls_r), .lane_write_select_n_fall(ls_f));

    // ==========================================================
    // Compare and access tasks
    // ==========================================================
    task automatic check_flag(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic check_word(input string nm, input logic [17:0] exp, input logic [17:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Words are only compared on the phases whose enable is expected high.
    task automatic chk_out(input logic oer, input logic oef, input logic [17:0] er,
                           input logic [17:0] ef);
        check_flag("rdata_oe_rise", oer, rdata_oe_rise);
        check_flag("rdata_oe_fall", oef, rdata_oe_fall);
        if (oer) check_word("rdata_rise", er, rdata_rise);
        if (oef) check_word("rdata_fall", ef, rdata_fall);
    endtask

    function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] nw,
                                          input logic [1:0] s_n);
        merge = old;
        if (!s_n[0]) merge[8:0] = nw[8:0];
        if (!s_n[1]) merge[17:9] = nw[17:9];
    endfunction

    // Burst of base+0..3; dbl repeats the write select on the next edge.
    task automatic wr_burst(input logic [7:0] a, input logic [17:0] base,
                            input logic [7:0] ln, input logic dbl);
        logic [17:0] d [4];
        for (int i = 0; i < 4; i++) d[i] = base + 18'(i);
        ctrl_u.step(1'b1, 1'b0, a, ~d[0], ~d[1], 2'h3, 2'h3);
        ctrl_u.step(1'b1, !dbl, a + 8'h20, d[0], d[1], ln[1:0], ln[3:2]);
        ctrl_u.step(1'b1, 1'b1, ~a, d[2], d[3], ln[5:4], ln[7:6]);
        ctrl_u.idle();
        for (int i = 0; i < 4; i++) model[a + 8'(i)] = merge(model[a + 8'(i)], d[i], ln[2*i +: 2]);
    endtask

    // Mode 1 repeats the read select; mode 2 lowers both selects at the start.
    task automatic rd_burst(input logic [7:0] a, input logic [1:0] md);
        logic [1:0] lz;
        lz = (md == 2'h2) ? 2'h0 : 2'h3;
        ctrl_u.step(1'b0, md != 2'h2, a, ~model[a], ~model[a], 2'h3, 2'h3);
        ctrl_u.step(md != 2'h1, 1'b1, a + 8'h08, ~model[a], ~model[a + 8'h01], lz, lz);
        ctrl_u.step(1'b1, 1'b1, ~a, ~model[a + 8'h02], ~model[a + 8'h03], lz, lz);
        #1;
        if (delay_loop_disable_n) chk_out(1'b0, 1'b1, model[a], model[a]);
        else chk_out(1'b1, 1'b1, model[a], model[a + 8'h01]);
        ctrl_u.idle();
        #1;
        if (delay_loop_disable_n) chk_out(1'b1, 1'b1, model[a + 8'h01], model[a + 8'h02]);
        else chk_out(1'b1, 1'b1, model[a + 8'h02], model[a + 8'h03]);
        ctrl_u.idle();
        #1;
        chk_out(delay_loop_disable_n, 1'b0, model[a + 8'h03], model[a]);
        ctrl_u.idle();
        #1;
        chk_out(1'b0, 1'b0, model[a], model[a]);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // A hang ends the run as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        rst = 1'b1;
        k_running = 1'b1;
        delay_loop_disable_n = 1'b1;
        output_clocks_high = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_out(1'b0, 1'b0, 18'h0_0000, 18'h0_0000);
        check_flag("single_clock_mode", 1'b0, single_clock_mode);
        repeat (10) @(posedge clk);
        #1 check_flag("dll_locked", 1'b0, dll_locked);
        repeat (10) @(posedge clk);
        #1 check_flag("dll_locked", 1'b1, dll_locked);
        $display("test reset_lock done");
        wr_burst(8'hfe, 18'h2_5a00, 8'h00, 1'b0);
        rd_burst(8'hfe, 2'h0);
        $display("test wrap_burst done");
        wr_burst(8'h10, 18'h0_1200, 8'h00, 1'b0);
        wr_burst(8'h10, 18'h3_fe00, 8'h1e, 1'b0);
        rd_burst(8'h10, 2'h0);
        $display("test lanes done");
        wr_burst(8'h40, 18'h1_4400, 8'h00, 1'b0);
        wr_burst(8'h20, 18'h2_2000, 8'h00, 1'b1);
        rd_burst(8'h40, 2'h1);
        rd_burst(8'h20, 2'h2);
        rd_burst(8'h20, 2'h0);
        $display("test refusals done");
        @(posedge clk);
        delay_loop_disable_n <= 1'b0;
        #1 check_flag("dll_locked", 1'b0, dll_locked);
        rd_burst(8'h10, 2'h0);
        $display("test legacy done");
        @(posedge clk);
        delay_loop_disable_n <= 1'b1;
        // Stop the clock one edge into a read, so the held word is a live one.
        ctrl_u.step(1'b0, 1'b1, 8'h10, 18'h0_0000, 18'h0_0000, 2'h3, 2'h3);
        ctrl_u.idle();
        ctrl_u.idle();
        k_running <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk_out(1'b0, 1'b1, model[8'h10], model[8'h10]);
        @(posedge clk);
        k_running <= 1'b1;
        #1 chk_out(1'b0, 1'b1, model[8'h10], model[8'h10]);
        @(posedge clk);
        #1 check_flag("dll_locked", 1'b0, dll_locked);
        chk_out(1'b1, 1'b1, model[8'h11], model[8'h12]);
        repeat (20) @(posedge clk);
        #1 check_flag("dll_locked", 1'b1, dll_locked);
        $display("test clock_stop done");
        @(posedge clk);
        output_clocks_high <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check_flag("single_clock_mode", 1'b1, single_clock_mode);
        rd_burst(8'hfe, 2'h0);
        $display("test strap done");
        wrap_up();
    end
endmodule // tb
